/* tuning_pkg.sv */
package tuning_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATE    = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_CLR  = 8'h0C;
   localparam logic [7:0] OFS_IRQ_EN   = 8'h10;
   localparam logic [7:0] OFS_FEAT_LO  = 8'h40;
   localparam logic [7:0] OFS_FEAT_HI  = 8'h44;
   // Control bits
   localparam int CTRL_START = 0;
   localparam int CTRL_SEL   = 1;
   // State register fields
   localparam int ST_FLAG    = 0;
   localparam int ST_PHASE   = 4;
   localparam int ST_TRIES   = 8;
   // Interrupt status bits
   localparam int IRQ_W      = 5;
   localparam int EV_CMD     = 0;
   localparam int EV_BUFRD   = 1;
   localparam int EV_RESPERR = 2;
   localparam int EV_TUNEERR = 3;
   localparam int EV_RETUNE  = 4;
   // Feature report fields (64-bit)
   localparam int FT_MULT    = 48;
   localparam int FT_METHOD  = 46;
   localparam int FT_MID     = 45;
   localparam int FT_TIMER   = 40;
   // Retuning methods
   localparam logic [1:0] METHOD_TIMER     = 2'h0;
   localparam logic [1:0] METHOD_TIMER_REQ = 2'h1;
   localparam logic [1:0] METHOD_AUTO      = 2'h2;
   // Tuning
   localparam logic [5:0] MAX_TRIES   = 6'h28;
   localparam int         PHASE_W     = 3;
   localparam logic [2:0] FIXED_PHASE = 3'h0;
   // Bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tuning_pkg

/* sampling_clock_tuning.sv */
// Notes on behaviour
// - Default operation samples command and data lines with a fixed, untuned phase.
// - Controller clears start on success or after forty failed attempts.
// - Select bit valid after start falls; one means success, zero failure.
// - During tuning only the read-buffer-ready interrupt may be raised.
// - Tuning command response errors are not reported during tuning.
// - Writing zero to select forces fixed clock and resets the tuning circuit.
// - Capability values are fixed constants.
// - Method two raises the retune flag when retuning is needed.
// - Method three retunes itself during transfers and raises no flag then.
module sampling_clock_tuning #(
   parameter logic [1:0] RETUNE_METHOD          = tuning_pkg::METHOD_TIMER_REQ,
   parameter logic [7:0] CLK_MULT               = 8'h00,
   parameter logic       TUNING_NEEDED_MIDSPEED = 1'b1,
   parameter logic [3:0] RETUNE_TIMER_INITIAL   = 4'h1
) (
   input  wire  logic        ref_clk,
   input  wire  logic        arst_n,
   input  wire  logic        card_clk,
   input  wire  logic        cmd_in,
   input  wire  logic [3:0]  dat_in,
   output logic              cmd_sample,
   output logic [3:0]        dat_sample,
   output logic              sample_strobe,
   output logic              use_tuned_clk,
   output logic [2:0]        sample_phase,
   output logic              auto_retune,
   input  wire  logic        tune_resp_done,
   input  wire  logic        tune_resp_pass,
   input  wire  logic        retune_trigger,
   input  wire  logic        xfer_active,
   input  wire  logic        cmd_complete_evt,
   input  wire  logic        buf_read_ready_evt,
   input  wire  logic        resp_err_evt,
   input  wire  logic        tuning_err_evt,
   output logic              irq,
   input  wire  logic [7:0]  s_axi_awaddr,
   input  wire  logic        s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire  logic [31:0] s_axi_wdata,
   input  wire  logic [3:0]  s_axi_wstrb,
   input  wire  logic        s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire  logic        s_axi_bready,
   input  wire  logic [7:0]  s_axi_araddr,
   input  wire  logic        s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire  logic        s_axi_rready
);

   typedef struct packed {
      logic        card_s1;
      logic        card_s2;
      logic        card_prev;
      logic        cmd_s1;
      logic        cmd_s2;
      logic [3:0]  dat_s1;
      logic [3:0]  dat_s2;
      logic [2:0]  edge_cnt;
      logic        cmd_smp;
      logic [3:0]  dat_smp;
      logic        smp_stb;
      logic        tune_start;
      logic        tuned_sel;
      logic [2:0]  phase;
      logic [5:0]  tries;
      logic        retune_flag;
      logic        auto_rt;
      logic [4:0]  stat;
      logic [4:0]  en;
      logic        irq;
      logic        aw_have;
      logic [7:0]  waddr;
      logic        w_have;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } state_type;

   state_type q;
   state_type d;

   // method encoding; multiplier N means N plus one
   localparam logic [63:0] FEATURE =
      (64'(CLK_MULT) << tuning_pkg::FT_MULT) |
      (64'(RETUNE_METHOD) << tuning_pkg::FT_METHOD) |
      (64'(TUNING_NEEDED_MIDSPEED) << tuning_pkg::FT_MID) |
      (64'(RETUNE_TIMER_INITIAL) << tuning_pkg::FT_TIMER);

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == tuning_pkg::OFS_CTRL) || (a == tuning_pkg::OFS_STATE) ||
               (a == tuning_pkg::OFS_IRQ_STAT) || (a == tuning_pkg::OFS_IRQ_CLR) ||
               (a == tuning_pkg::OFS_IRQ_EN) || (a == tuning_pkg::OFS_FEAT_LO) ||
               (a == tuning_pkg::OFS_FEAT_HI);
   endfunction : mapped

   logic [2:0] eff_phase;
   logic [4:0] ev;
   logic       do_wr;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      d = q;
      d.auto_rt = 1'b0;
      d.smp_stb = 1'b0;
      // Link sampling: two flops before anything looks at the pins
      d.card_s1 = card_clk;
      d.card_s2 = q.card_s1;
      d.card_prev = q.card_s2;
      d.cmd_s1 = cmd_in;
      d.cmd_s2 = q.cmd_s1;
      d.dat_s1 = dat_in;
      d.dat_s2 = q.dat_s1;
      // fixed phase unless tuning or tuned
      eff_phase = (q.tune_start || q.tuned_sel) ? q.phase : tuning_pkg::FIXED_PHASE;
      if (q.card_s2 && !q.card_prev) begin
         d.edge_cnt = 3'h0;
      end else if (q.edge_cnt != 3'h7) begin
         d.edge_cnt = q.edge_cnt + 3'h1;
      end
      // Counter parks at seven so a stopped card clock gives no samples
      if (d.edge_cnt == eff_phase && (d.edge_cnt != q.edge_cnt || (q.card_s2 && !q.card_prev))) begin
         d.cmd_smp = q.cmd_s2;
         d.dat_smp = q.dat_s2;
         d.smp_stb = 1'b1;
      end

      // tuning attempts end on success or after the last try
      // select reports the outcome when start falls
      if (q.tune_start && tune_resp_done) begin
         if (tune_resp_pass) begin
            d.tune_start = 1'b0;
            d.tuned_sel = 1'b1;
         end else if (q.tries == tuning_pkg::MAX_TRIES - 6'h1) begin
            d.tune_start = 1'b0;
            d.tuned_sel = 1'b0;
            d.tries = tuning_pkg::MAX_TRIES;
         end else begin
            d.tries = q.tries + 6'h1;
            d.phase = q.phase + 3'h1;
         end
      end

      // AXI write channel: address and data taken in either order
      if (s_axi_awvalid && q.awready) begin
         d.aw_have = 1'b1;
         d.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_have = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      do_wr = q.aw_have && q.w_have && !q.bvalid;
      if (s_axi_bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (do_wr) begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = mapped(q.waddr) ? tuning_pkg::RESP_OKAY : tuning_pkg::RESP_SLVERR;
         if (q.wstrb[0]) begin
            case (q.waddr)
               tuning_pkg::OFS_CTRL: begin
                  // only a one starts; software never clears start
                  if (q.wdata[tuning_pkg::CTRL_START] && !q.tune_start) begin
                     d.tune_start = 1'b1;
                     d.tries = 6'h0;
                     d.retune_flag = 1'b0;
                  end
                  // zero on select resets the tuning circuit
                  if (!q.wdata[tuning_pkg::CTRL_SEL]) begin
                     d.tuned_sel = 1'b0;
                     d.phase = tuning_pkg::FIXED_PHASE;
                     d.tries = 6'h0;
                  end
               end
               tuning_pkg::OFS_IRQ_CLR: d.stat = q.stat & ~q.wdata[4:0];
               tuning_pkg::OFS_IRQ_EN:  d.en = q.wdata[4:0];
               default: ;
            endcase
         end
      end

      // method two flags retune need; method three retunes itself during transfers, else flags
      if (retune_trigger && q.tuned_sel && !q.tune_start) begin
         if (RETUNE_METHOD == tuning_pkg::METHOD_AUTO && xfer_active) begin
            d.auto_rt = 1'b1;
         end else if (RETUNE_METHOD != tuning_pkg::METHOD_TIMER) begin
            d.retune_flag = 1'b1;
         end
      end

      ev = 5'h0;
      ev[tuning_pkg::EV_BUFRD] = buf_read_ready_evt;
      if (!q.tune_start) begin
         ev[tuning_pkg::EV_CMD] = cmd_complete_evt;
         ev[tuning_pkg::EV_RESPERR] = resp_err_evt;
         ev[tuning_pkg::EV_TUNEERR] = tuning_err_evt;
         ev[tuning_pkg::EV_RETUNE] = d.retune_flag && !q.retune_flag;
      end
      // Set wins over a clear in the same cycle
      d.stat = d.stat | ev;
      d.irq = |(d.stat & d.en);

      // AXI read channel
      if (s_axi_rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rresp = mapped(s_axi_araddr) ? tuning_pkg::RESP_OKAY : tuning_pkg::RESP_SLVERR;
         case (s_axi_araddr)
            tuning_pkg::OFS_CTRL:
               d.rdata = {30'h0, q.tuned_sel, q.tune_start};
            tuning_pkg::OFS_STATE:
               d.rdata = {18'h0, q.tries, 1'b0, q.phase, 3'h0, q.retune_flag};
            tuning_pkg::OFS_IRQ_STAT: d.rdata = {27'h0, q.stat};
            tuning_pkg::OFS_IRQ_EN:   d.rdata = {27'h0, q.en};
            tuning_pkg::OFS_FEAT_LO:  d.rdata = FEATURE[31:0];
            tuning_pkg::OFS_FEAT_HI:  d.rdata = FEATURE[63:32];
            default:                  d.rdata = 32'h0;
         endcase
      end
      // One outstanding transaction per direction
      d.awready = !d.aw_have && !d.bvalid;
      d.wready = !d.w_have && !d.bvalid;
      d.arready = !d.rvalid;
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign cmd_sample = q.cmd_smp;
   assign dat_sample = q.dat_smp;
   assign sample_strobe = q.smp_stb;
   assign use_tuned_clk = q.tuned_sel;
   assign sample_phase = q.phase;
   assign auto_retune = q.auto_rt;
   assign irq = q.irq;
   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;

   ////////////////////////////////////////////////////////////////////////
   sequence seq_last_fail;
      q.tune_start && tune_resp_done && !tune_resp_pass && q.tries == 6'h27;
   endsequence
   sequence seq_pass;
      q.tune_start && tune_resp_done && tune_resp_pass;
   endsequence
   sequence seq_sel_zero;
      q.aw_have && q.w_have && !q.bvalid && q.waddr == tuning_pkg::OFS_CTRL &&
      q.wstrb[0] && !q.wdata[tuning_pkg::CTRL_SEL];
   endsequence

   a_fail_ends_tuning: assert property (@(posedge ref_clk) disable iff (!arst_n)
      seq_last_fail |=> !q.tune_start && !q.tuned_sel)
      else $error("tuning did not stop after last failed try");
   a_pass_selects_tuned: assert property (@(posedge ref_clk) disable iff (!arst_n)
      seq_pass |=> !q.tune_start && q.tuned_sel)
      else $error("tuning pass not reported");
   a_tries_bounded: assert property (@(posedge ref_clk) disable iff (!arst_n)
      q.tries <= 6'h28)
      else $error("try count above limit");
   a_sel_zero_resets: assert property (@(posedge ref_clk) disable iff (!arst_n)
      seq_sel_zero |=> !q.tuned_sel && q.phase == 3'h0 && q.tries == 6'h0)
      else $error("select zero did not reset circuit");
   a_fixed_phase_used: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (!q.tune_start && !q.tuned_sel && q.card_s2 && !q.card_prev) |=> q.smp_stb)
      else $error("fixed sampling phase not used");
   a_no_cmd_irq: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (q.tune_start && !q.stat[0]) |=> !q.stat[0])
      else $error("command interrupt raised while tuning");
   a_no_resp_err: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (q.tune_start && !q.stat[2]) |=> !q.stat[2])
      else $error("response error reported while tuning");
   a_auto_no_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (RETUNE_METHOD == tuning_pkg::METHOD_AUTO && xfer_active && !q.retune_flag && !q.tune_start)
      |=> !q.retune_flag && !$rose(q.stat[4]))
      else $error("flag raised during automatic retune");
   a_method2_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (RETUNE_METHOD == tuning_pkg::METHOD_TIMER_REQ && retune_trigger && q.tuned_sel &&
       !q.tune_start && !q.retune_flag) |=> q.retune_flag ##1 q.stat[4])
      else $error("retune flag not raised");
   a_irq_level: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ((q.stat & q.en) != 5'h0) |-> q.irq)
      else $error("interrupt low with enabled status");

endmodule : sampling_clock_tuning

/* card_model.sv */
module card_model (
   input  wire logic       run,
   output logic            card_clk,
   output logic            cmd_in,
   output logic [3:0]      dat_in
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      card_clk = 1'b0;
      cmd_in   = 1'b1;
      dat_in   = 4'hF;
   end

   // Card clock stands still between frames, lines change every bit
   always begin
      wait (run);
      // Edges kept off the controller clock edge
      #150 card_clk = 1'b1;
      cmd_in = ~cmd_in;
      dat_in = dat_in + 4'h1;
      #160 card_clk = 1'b0;
      #10;
   end
endmodule : card_model

/* sampling_clock_tuning_tb.sv */
module sampling_clock_tuning_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        ref_clk = 1'b0;
   logic        arst_n  = 1'b0;
   logic        run     = 1'b0;
   logic        card_clk, cmd_in, cmd_sample, sample_strobe, use_tuned_clk, irq;
   logic [3:0]  dat_in, dat_sample;
   logic [2:0]  sample_phase;
   logic        done_p = 1'b0, pass_l = 1'b0, xfer = 1'b0;
   logic [4:0]  evt = 5'h00;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [1:0]  bresp, rresp, r;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, awready, wready, bvalid, arready, rvalid;
   int          error_cnt = 0, num_checks = 0, strobe_cnt = 0, cyc = 0;
   logic        auto_rt, auto_rt2, irq2, trig2 = 1'b0;
   int          auto_cnt = 0, auto_cnt2 = 0;

   always #20 ref_clk = ~ref_clk;

   card_model card_model_i (.run(run), .card_clk(card_clk), .cmd_in(cmd_in), .dat_in(dat_in));

   sampling_clock_tuning sampling_clock_tuning_i (
      .ref_clk(ref_clk), .arst_n(arst_n), .card_clk(card_clk), .cmd_in(cmd_in), .dat_in(dat_in),
      .cmd_sample(cmd_sample), .dat_sample(dat_sample), .sample_strobe(sample_strobe),
      .use_tuned_clk(use_tuned_clk), .sample_phase(sample_phase), .auto_retune(auto_rt),
      .tune_resp_done(done_p), .tune_resp_pass(pass_l), .retune_trigger(evt[4]), .xfer_active(xfer),
      .cmd_complete_evt(evt[0]), .buf_read_ready_evt(evt[1]), .resp_err_evt(evt[2]),
      .tuning_err_evt(evt[3]), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'b1)
   );

   // Automatic retune build shares the bus; only its retune pulse and irq are watched
   sampling_clock_tuning #(.RETUNE_METHOD(tuning_pkg::METHOD_AUTO)) sampling_clock_tuning_auto_i (
      .ref_clk(ref_clk), .arst_n(arst_n), .card_clk(card_clk), .cmd_in(cmd_in), .dat_in(dat_in),
      .cmd_sample(), .dat_sample(), .sample_strobe(), .use_tuned_clk(), .sample_phase(),
      .auto_retune(auto_rt2), .tune_resp_done(done_p), .tune_resp_pass(pass_l), .retune_trigger(trig2),
      .xfer_active(xfer), .cmd_complete_evt(evt[0]), .buf_read_ready_evt(evt[1]), .resp_err_evt(evt[2]),
      .tuning_err_evt(evt[3]), .irq(irq2),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
      .s_axi_bvalid(), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(1'b1)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize

   // Hang guard, generous against about 300 cycles of tests
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (sample_strobe === 1'b1) strobe_cnt <= strobe_cnt + 1;
      if (auto_rt === 1'b1) auto_cnt <= auto_cnt + 1;
      if (auto_rt2 === 1'b1) auto_cnt2 <= auto_cnt2 + 1;
      if (cyc == 6000) begin
         error_cnt++;
         summarize();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done  = 1'b0;
      @(posedge ref_clk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge ref_clk);
         if (awready === 1'b1 && !aw_done) begin aw_done = 1'b1; awvalid <= 1'b0; end
         if (wready === 1'b1 && !w_done) begin w_done = 1'b1; wvalid <= 1'b0; end
      end
      do @(posedge ref_clk); while (bvalid !== 1'b1);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      @(posedge ref_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      do @(posedge ref_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge ref_clk); while (rvalid !== 1'b1);
      v    = rdata;
      resp = rresp;
   endtask : rd

   task automatic pulse(input logic [4:0] e);
      @(posedge ref_clk) evt <= e;
      @(posedge ref_clk) evt <= 5'h00;
   endtask : pulse

   // one tuning block result per call
   task automatic tune(input logic pass);
      @(posedge ref_clk);
      done_p <= 1'b1;
      pass_l <= pass;
      @(posedge ref_clk) done_p <= 1'b0;
      // One more edge so the result is visible to the caller
      @(posedge ref_clk);
   endtask : tune

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rd(tuning_pkg::OFS_FEAT_HI, d, r);
      check(d, 32'h00006100);
      check(d & 32'h00FF0000, 32'h0);
      rd(8'h20, d, r);
      check({30'h0, r}, {30'h0, tuning_pkg::RESP_SLVERR});
      $display("feature report test done");
      run <= 1'b1;
      repeat (30) @(posedge ref_clk);
      run <= 1'b0;
      repeat (16) @(posedge ref_clk);
      check(strobe_cnt, 32'h4);
      check({31'h0, use_tuned_clk}, 32'h0);
      check({29'h0, sample_phase}, 32'h0);
      check({27'h0, cmd_sample, dat_sample}, 32'h13);
      $display("fixed sampling test done");
      wr(tuning_pkg::OFS_IRQ_EN, 32'h0000001F);
      wr(tuning_pkg::OFS_CTRL, 32'h00000001);
      rd(tuning_pkg::OFS_CTRL, d, r);
      check(d & 32'h1, 32'h1);
      pulse(5'h07);
      rd(tuning_pkg::OFS_IRQ_STAT, d, r);
      check(d, 32'h00000002);
      check(d & 32'h4, 32'h0);
      repeat (3) tune(1'b0);
      check({29'h0, sample_phase}, 32'h3);
      tune(1'b1);
      rd(tuning_pkg::OFS_CTRL, d, r);
      check(d & 32'h3, 32'h2);
      check({31'h0, use_tuned_clk}, 32'h1);
      rd(tuning_pkg::OFS_STATE, d, r);
      check((d >> 8) & 32'h3F, 32'h3);
      $display("tuning success test done");
      wr(tuning_pkg::OFS_IRQ_CLR, 32'h0000001F);
      check({31'h0, irq}, 32'h0);
      @(posedge ref_clk);
      xfer  <= 1'b1;
      trig2 <= 1'b1;
      @(posedge ref_clk) trig2 <= 1'b0;
      @(posedge ref_clk) xfer <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check(auto_cnt2, 32'h1);
      check({31'h0, irq2}, 32'h0);
      check(auto_cnt, 32'h0);
      $display("automatic retune test done");
      pulse(5'h19);
      rd(tuning_pkg::OFS_STATE, d, r);
      check(d & 32'h1, 32'h1);
      rd(tuning_pkg::OFS_IRQ_STAT, d, r);
      check(d, 32'h00000019);
      check({31'h0, irq}, 32'h1);
      wr(tuning_pkg::OFS_IRQ_EN, 32'h0);
      check({31'h0, irq}, 32'h0);
      wr(tuning_pkg::OFS_IRQ_CLR, 32'h0000001F);
      rd(tuning_pkg::OFS_IRQ_STAT, d, r);
      check(d, 32'h0);
      $display("interrupt test done");
      // retune request seen, tune before the next command
      // start with select kept at one
      wr(tuning_pkg::OFS_CTRL, 32'h00000003);
      tune(1'b1);
      check({28'h0, use_tuned_clk, sample_phase}, 32'hB);
      rd(tuning_pkg::OFS_STATE, d, r);
      check(d & 32'h1, 32'h0);
      $display("retune test done");
      // tuning error seen, clear select before tuning again
      wr(tuning_pkg::OFS_CTRL, 32'h0);
      rd(tuning_pkg::OFS_CTRL, d, r);
      check(d & 32'h3, 32'h0);
      check({28'h0, use_tuned_clk, sample_phase}, 32'h0);
      $display("circuit reset test done");
      wr(tuning_pkg::OFS_CTRL, 32'h00000001);
      repeat (39) tune(1'b0);
      rd(tuning_pkg::OFS_CTRL, d, r);
      check(d & 32'h1, 32'h1);
      tune(1'b0);
      rd(tuning_pkg::OFS_CTRL, d, r);
      check(d & 32'h3, 32'h0);
      rd(tuning_pkg::OFS_STATE, d, r);
      check((d >> 8) & 32'h3F, 32'(tuning_pkg::MAX_TRIES));
      // give up and fall back to the fixed clock
      wr(tuning_pkg::OFS_CTRL, 32'h0);
      check({28'h0, use_tuned_clk, sample_phase}, 32'h0);
      $display("tuning failure test done");
      summarize();
   end
endmodule : sampling_clock_tuning_tb
